//--- hw/twm_consts.svh
// Constants for the two-wire master: register offsets, field positions, reset values and response codes.
// Function
// - Idle flag rises at once on NAK.
// - Disable releases both lines high on the third link-clock edge after the write.
// - Alert input is active high.
// - Alert flag may read set after reset.
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH
`define TWM_OFF_CTRL      12'h000
`define TWM_OFF_CMD       12'h004
`define TWM_OFF_STATUS    12'h008
`define TWM_OFF_CLEAR     12'h00C
`define TWM_OFF_DIV       12'h010
`define TWM_OFF_RXDATA    12'h014
`define TWM_CTRL_EN       0
`define TWM_CTRL_DIS      1
`define TWM_CMD_READ      8
`define TWM_CMD_ADDR_LSB  9
`define TWM_CMD_NB_LSB    16
`define TWM_ST_IDLE       0
`define TWM_ST_NAK        1
`define TWM_ST_ALERT      2
`define TWM_ST_DONE       3
`define TWM_ST_ENABLED    4
`define TWM_ALERT_RST     1'b1
`define TWM_DIV_RST       8'h04
`define TWM_RESP_OKAY     2'h0
`define TWM_RESP_SLVERR   2'h2
`endif

//--- hw/twm_pkg.sv
// Types shared by the two-wire master files.
package twm_pkg;
  typedef enum logic [2:0] {
    TWM_IDLE  = 3'h0,
    TWM_START = 3'h1,
    TWM_BITS  = 3'h3,
    TWM_ACK   = 3'h2,
    TWM_STOP  = 3'h6,
    TWM_STOP2 = 3'h7
  } twm_state_e;
endpackage

//--- hw/twm_link_if.sv
// Signals between the register side and the serial engine.
`timescale 1ns/1ns
`default_nettype none
interface twm_link_if;
  logic       go_tgl;
  logic       rd;
  logic [6:0] addr;
  logic [7:0] nbytes;
  logic [7:0] txbyte;
  logic [7:0] div;
  logic       dis;
  logic       busy;
  logic       nak_tgl;
  logic       done_tgl;
  logic [7:0] rxbyte;
  modport regs (output go_tgl, rd, addr, nbytes, txbyte, div, dis,
                input busy, nak_tgl, done_tgl, rxbyte);
  modport eng  (input go_tgl, rd, addr, nbytes, txbyte, div, dis,
                output busy, nak_tgl, done_tgl, rxbyte);
endinterface
`default_nettype wire

//--- hw/twm_engine.sv
// Serial engine of the two-wire master, clocked by the link clock.
`timescale 1ns/1ns
`default_nettype none
module twm_engine
  import twm_pkg::*;
(
  input  wire logic link_clock,
  input  wire logic link_rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe,
  output logic      sda_oe,
  twm_link_if.eng   lk
);
  typedef struct packed {
    logic [2:0] go_s;
    logic [1:0] dis_s;
    logic [1:0] sda_s;
    twm_state_e st;
    logic [7:0] cnt;
    logic       ph;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [7:0] left;
    logic       scl_lo;
    logic       sda_lo;
    logic       nak_t;
    logic       done_t;
    logic       busy;
    logic [7:0] rx;
  } twm_eng_s;
  twm_eng_s s_reg, s_next;
  logic go;
  assign go = s_reg.go_s[2] ^ s_reg.go_s[1];
  always_comb
  begin
    s_next = s_reg;
    s_next.go_s = {s_reg.go_s[1:0], lk.go_tgl};
    s_next.dis_s = {s_reg.dis_s[0], lk.dis};
    s_next.sda_s = {s_reg.sda_s[0], sda_in};
    s_next.cnt = (s_reg.cnt == 8'h00) ? lk.div : s_reg.cnt - 8'h01;
    if (s_reg.cnt == 8'h00 && s_reg.st != TWM_IDLE)
    begin
      s_next.ph = ~s_reg.ph;
      case (s_reg.st)
        TWM_START:
        begin
          s_next.sda_lo = 1'b1;
          s_next.st = TWM_BITS;
          s_next.bitn = 4'h0;
          // Every byte opens on the low half, so no bit is shifted before its pulse.
          s_next.ph = 1'b0;
        end
        TWM_BITS:
        begin
          if (!s_reg.ph)
          begin
            s_next.scl_lo = 1'b1;
            s_next.sda_lo = ~s_reg.sh[8];
          end
          else
          begin
            s_next.scl_lo = 1'b0;
            s_next.rx = {s_reg.rx[6:0], s_reg.sda_s[1]};
            s_next.sh = {s_reg.sh[7:0], 1'b1};
            s_next.bitn = s_reg.bitn + 4'h1;
            if (s_reg.bitn == 4'h8)
              s_next.st = TWM_ACK;
          end
        end
        TWM_ACK:
        begin
          s_next.scl_lo = 1'b1;
          s_next.sda_lo = 1'b1;
          s_next.bitn = 4'h0;
          if (s_reg.rx[0] && !lk.rd && s_reg.left != 8'h00)
          begin
            s_next.nak_t = ~s_reg.nak_t;
            s_next.busy = 1'b0;
            s_next.st = TWM_STOP;
          end
          else if (s_reg.left == 8'h00)
            s_next.st = TWM_STOP;
          else
          begin
            s_next.left = s_reg.left - 8'h01;
            s_next.sh = {lk.txbyte, (s_reg.left != 8'h01) || !lk.rd};
            s_next.ph = 1'b0;
            s_next.st = TWM_BITS;
          end
        end
        TWM_STOP:
        begin
          s_next.scl_lo = 1'b0;
          s_next.st = TWM_STOP2;
        end
        default:
        begin
          s_next.sda_lo = 1'b0;
          s_next.busy = 1'b0;
          s_next.done_t = ~s_reg.done_t;
          s_next.st = TWM_IDLE;
        end
      endcase
    end
    if (s_reg.st == TWM_IDLE && go)
    begin
      s_next.st = TWM_START;
      s_next.busy = 1'b1;
      s_next.ph = 1'b0;
      s_next.left = lk.nbytes;
      s_next.sh = {lk.addr, lk.rd, 1'b1};
    end
    if (s_reg.dis_s[1])
    begin
      s_next.scl_lo = 1'b0;
      s_next.sda_lo = 1'b0;
      s_next.st = TWM_IDLE;
      s_next.busy = 1'b0;
    end
  end
  always_ff @(posedge link_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign scl_oe = s_reg.scl_lo;
  assign sda_oe = s_reg.sda_lo;
  assign lk.busy = s_reg.busy;
  assign lk.nak_tgl = s_reg.nak_t;
  assign lk.done_tgl = s_reg.done_t;
  assign lk.rxbyte = s_reg.rx;
endmodule // twm_engine
`default_nettype wire

//--- hw/twm_top.sv
// Two-wire master: AXI4-Lite register slave and clock-domain crossings.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "twm_consts.svh"
module twm_top
  import twm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        link_clock,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  input  wire logic        bus_alert_input
);
  typedef struct packed {
    logic [11:0] awa;
    logic        aw_h;
    logic [31:0] wd;
    logic        w_h;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic        en;
    logic        dis;
    logic        go_t;
    logic        rdir;
    logic [6:0]  addr;
    logic [7:0]  nb;
    logic [7:0]  txb;
    logic [7:0]  rxb;
    logic [7:0]  div;
    logic        alert;
    logic        nak;
    logic        done;
    logic [1:0]  al_s;
    logic [1:0]  busy_s;
    logic [2:0]  nak_s;
    logic [2:0]  done_s;
  } twm_top_s;
  twm_top_s s_reg, s_next;
  twm_link_if lk ();
  logic [1:0] lrst_s;
  logic       idle;
  ////////////////////////////////////////////////////////////////////////////
  // A toggle that has crossed shows as a difference between its last two stages.
  function automatic logic tgl_edge(input logic [2:0] stages);
    tgl_edge = stages[2] ^ stages[1];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Link-side reset is released synchronously to the link clock.
  always_ff @(posedge link_clock or negedge rst_n)
  begin
    if (!rst_n)
      lrst_s <= 2'h0;
    else
      lrst_s <= {lrst_s[0], 1'b1};
  end
  twm_engine u_eng (
    .link_clock (link_clock),
    .link_rst_n (lrst_s[1]),
    .scl_in     (serial_clock_line_in),
    .sda_in     (serial_data_line_in),
    .scl_oe     (serial_clock_line_oe),
    .sda_oe     (serial_data_line_oe),
    .lk         (lk)
  );
  assign lk.go_tgl = s_reg.go_t;
  assign lk.rd = s_reg.rdir;
  assign lk.addr = s_reg.addr;
  assign lk.nbytes = s_reg.nb;
  assign lk.txbyte = s_reg.txb;
  assign lk.div = s_reg.div;
  assign lk.dis = s_reg.dis;
  // Open-drain pins: the level is always low and only the enable pulls the line.
  assign serial_clock_line_out = 1'b0;
  assign serial_data_line_out = 1'b0;
  assign idle = ~s_reg.busy_s[1];
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    s_next.al_s = {s_reg.al_s[0], bus_alert_input};
    s_next.busy_s = {s_reg.busy_s[0], lk.busy};
    s_next.nak_s = {s_reg.nak_s[1:0], lk.nak_tgl};
    s_next.done_s = {s_reg.done_s[1:0], lk.done_tgl};
    if (s_axi_awvalid && !s_reg.aw_h)
    begin
      s_next.awa = s_axi_awaddr;
      s_next.aw_h = 1'b1;
    end
    if (s_axi_wvalid && !s_reg.w_h)
    begin
      s_next.wd = s_axi_wdata;
      s_next.w_h = 1'b1;
    end
    if (s_reg.aw_h && s_reg.w_h && !s_reg.bv)
    begin
      s_next.aw_h = 1'b0;
      s_next.w_h = 1'b0;
      s_next.bv = 1'b1;
      s_next.br = `TWM_RESP_OKAY;
      if (s_reg.awa == `TWM_OFF_CTRL)
      begin
        if (s_reg.wd[`TWM_CTRL_EN])
        begin
          s_next.en = 1'b1;
          s_next.dis = 1'b0;
        end
        if (s_reg.wd[`TWM_CTRL_DIS])
        begin
          s_next.en = 1'b0;
          s_next.dis = 1'b1;
        end
      end
      else if (s_reg.awa == `TWM_OFF_CMD)
      begin
        s_next.txb = s_reg.wd[7:0];
        s_next.rdir = s_reg.wd[`TWM_CMD_READ];
        s_next.addr = s_reg.wd[`TWM_CMD_ADDR_LSB +: 7];
        s_next.nb = s_reg.wd[`TWM_CMD_NB_LSB +: 8];
        // A command while busy or disabled only updates the stored fields.
        if (s_reg.en && idle)
        begin
          s_next.go_t = ~s_reg.go_t;
          s_next.done = 1'b0;
        end
      end
      else if (s_reg.awa == `TWM_OFF_CLEAR)
      begin
        if (s_reg.wd[`TWM_ST_NAK])
          s_next.nak = 1'b0;
        if (s_reg.wd[`TWM_ST_ALERT])
          s_next.alert = 1'b0;
        if (s_reg.wd[`TWM_ST_DONE])
          s_next.done = 1'b0;
      end
      else if (s_reg.awa == `TWM_OFF_DIV)
        s_next.div = s_reg.wd[7:0];
      // Writes to unmapped or read-only words answer with an error and change nothing.
      else
        s_next.br = `TWM_RESP_SLVERR;
    end
    // Set wins over a same-cycle software clear.
    if (tgl_edge(s_reg.nak_s))
      s_next.nak = 1'b1;
    // The receive byte is copied only once the done toggle has crossed, so a
    // read never catches the engine's shift register in motion.
    if (tgl_edge(s_reg.done_s))
    begin
      s_next.done = 1'b1;
      s_next.rxb = lk.rxbyte;
    end
    if (s_reg.al_s[1])
      s_next.alert = 1'b1;
    if (s_reg.bv && s_axi_bready)
      s_next.bv = 1'b0;
    if (s_axi_arvalid && !s_reg.rv)
    begin
      s_next.rv = 1'b1;
      s_next.rr = `TWM_RESP_OKAY;
      s_next.rd = 32'h0000_0000;
      if (s_axi_araddr == `TWM_OFF_CTRL)
        s_next.rd = {30'h0, s_reg.dis, s_reg.en};
      else if (s_axi_araddr == `TWM_OFF_CMD)
        s_next.rd = {8'h00, s_reg.nb, s_reg.addr, s_reg.rdir, s_reg.txb};
      else if (s_axi_araddr == `TWM_OFF_STATUS)
        // Idle follows the engine, so it rises on a NAK before the stop is out.
        s_next.rd = {27'h0, s_reg.en, s_reg.done, s_reg.alert, s_reg.nak, idle};
      else if (s_axi_araddr == `TWM_OFF_DIV)
        s_next.rd = {24'h0, s_reg.div};
      else if (s_axi_araddr == `TWM_OFF_RXDATA)
        s_next.rd = {24'h0, s_reg.rxb};
      else
        s_next.rr = `TWM_RESP_SLVERR;
    end
    if (s_reg.rv && s_axi_rready)
      s_next.rv = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.alert <= `TWM_ALERT_RST;
      s_reg.div <= `TWM_DIV_RST;
    end
    else
      s_reg <= s_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Write readies come straight from the hold flags, read ready from the read valid flag; every data output is a flop.
  assign s_axi_awready = ~s_reg.aw_h;
  assign s_axi_wready = ~s_reg.w_h;
  assign s_axi_bvalid = s_reg.bv;
  assign s_axi_bresp = s_reg.br;
  assign s_axi_arready = ~s_reg.rv;
  assign s_axi_rvalid = s_reg.rv;
  assign s_axi_rdata = s_reg.rd;
  assign s_axi_rresp = s_reg.rr;
endmodule // twm_top
`default_nettype wire

//--- tb/twm_props.sv
// Checker for the two-wire master's port behaviour.
`timescale 1ns/1ns
`default_nettype none
module twm_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        serial_clock_line_oe,
  input wire logic        serial_data_line_oe,
  input wire logic        bus_alert_input
);
  logic [11:0] wa_reg;
  logic [11:0] ra_reg;
  logic [31:0] wd_reg;
  logic [3:0]  low_reg;
  logic        clr_reg;
  logic        quiet_reg;
  logic        clr_w;
  assign clr_w = s_axi_bvalid && wa_reg == 12'h00C && wd_reg[2];
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      wa_reg    <= 12'h000;
      ra_reg    <= 12'h000;
      wd_reg    <= 32'h0000_0000;
      low_reg   <= 4'h0;
      clr_reg   <= 1'b0;
      quiet_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_reg <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
      if (clr_w) clr_reg <= 1'b1;
      low_reg <= bus_alert_input ? 4'h0 : low_reg + {3'h0, low_reg != 4'hF};
      // Eight quiet cycles let the synchroniser drain, so set-wins cannot hit the clear.
      quiet_reg <= !bus_alert_input && (quiet_reg || (clr_w && low_reg[3]));
    end
  ////////////////////////////////////////////////////////////
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_nak_idle: assert property ($rose(s_axi_rvalid) && ra_reg == 12'h008
    && s_axi_rdata[1] |-> s_axi_rdata[0]) else $error("nak seen without idle");
  a_dis_release: assert property ($rose(s_axi_bvalid) && wa_reg == 12'h000
    && wd_reg[1] |-> ##[1:80] !serial_clock_line_oe && !serial_data_line_oe)
    else $error("lines not released");
  a_alert_high: assert property (bus_alert_input [*6] ##1
    ($rose(s_axi_rvalid) && ra_reg == 12'h008) |-> s_axi_rdata[2]) else $error("alert lost");
  a_alert_reset: assert property ($rose(s_axi_rvalid) && ra_reg == 12'h008
    && !clr_reg |-> s_axi_rdata[2]) else $error("alert flag clear after reset");
  a_alert_clear: assert property ($rose(s_axi_rvalid) && ra_reg == 12'h008
    && quiet_reg |-> !s_axi_rdata[2]) else $error("alert flag not cleared");
endmodule // twm_props
bind twm_top twm_props u_props (.*);
`default_nettype wire

//--- tb/twm_slave.sv
// Behavioural two-wire slave that acknowledges one address.
`timescale 1ns/1ns
`default_nettype none
module twm_slave #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nak_data,
  output logic      sda_pull
);
  int         bit_cnt = 0;
  logic       active = 1'b0;
  logic       addr_ph = 1'b0;
  logic [7:0] shift = 8'h00;
  initial sda_pull = 1'b0;
  // Start and stop are judged 1 ns after the data edge, so a data change made
  // in the same step as the clock's fall is never taken for either.
  always @(negedge sda)
  begin
    #1;
    if (scl)
    begin
      active  = 1'b1;
      addr_ph = 1'b1;
      bit_cnt = 0;
    end
  end
  always @(posedge sda)
  begin
    #1;
    if (scl) active = 1'b0;
  end
  always @(posedge scl)
    if (active && bit_cnt < 8)
    begin
      shift   = {shift[6:0], sda};
      bit_cnt = bit_cnt + 1;
    end
  // Acknowledge changes only while the clock is low, as a real slave must.
  always @(negedge scl)
    if (active && bit_cnt == 8)
    begin
      sda_pull = addr_ph ? shift[7:1] == ADDR : !nak_data;
      bit_cnt  = 9;
    end
    else if (bit_cnt == 9)
    begin
      sda_pull = 1'b0;
      addr_ph  = 1'b0;
      bit_cnt  = 0;
    end
endmodule // twm_slave
`default_nettype wire

//--- tb/two_wire_master_quirks_tb_top.sv
// Self-checking bench for the two-wire master.
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_quirks_tb_top;
  logic        clock = 1'b0, rst_n = 1'b0, link_clock = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bus_alert_input = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        serial_clock_line_out, serial_clock_line_oe, serial_data_line_out;
  logic        serial_data_line_oe, nak_data = 1'b0, slave_pull;
  wire logic   serial_clock_line_in = !serial_clock_line_oe;
  wire logic   serial_data_line_in = !(serial_data_line_oe || slave_pull);
  int          fails = 0, checks_done = 0, cyc = 0;
  twm_top uut (.*);
  twm_slave u_slave (.scl(serial_clock_line_in), .sda(serial_data_line_in),
                     .nak_data(nak_data), .sda_pull(slave_pull));
  always #4 clock = !clock;
  always
  begin
    #62 link_clock = 1'b1;
    #63 link_clock = 1'b0;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge clock);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clock);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_alert();
    rd(12'h008);
    chk(rd_data[2], 1'b1);
    wr(12'h00C, 32'h0000_0004);
    rd(12'h008);
    chk(rd_data[2], 1'b0);
    bus_alert_input <= 1'b1;
    repeat (8) @(posedge clock);
    rd(12'h008);
    chk(rd_data[2], 1'b1);
    bus_alert_input <= 1'b0;
    repeat (8) @(posedge clock);
    wr(12'h00C, 32'h0000_0004);
    rd(12'h008);
    chk(rd_data[2], 1'b0);
    rd(12'h020);
    chk(resp, 2'h2);
    wr(12'h008, 32'h0000_0000);
    chk(resp, 2'h2);
    rd(12'h010);
    chk(rd_data, 32'h0000_0004);
    $display("test alert done");
  endtask
  task automatic t_nak();
    nak_data <= 1'b1;
    wr(12'h000, 32'h0000_0001);
    wr(12'h004, 32'h0003_545A);
    rd_data = 32'h0000_0000;
    for (int i = 0; i < 2000 && !rd_data[1]; i++) rd(12'h008);
    chk(rd_data[1:0], 2'h3);
    // Idle already shows while the stop is still on its way.
    chk(serial_data_line_oe, 1'b1);
    // Two bit periods at the reset divider let the stop finish before disabling.
    repeat (320) @(posedge clock);
    rd(12'h008);
    chk(rd_data, 32'h0000_001B);
    wr(12'h000, 32'h0000_0002);
    wr(12'h00C, 32'h0000_000E);
    $display("test nak done");
  endtask
  task automatic t_dis();
    nak_data <= 1'b0;
    wr(12'h000, 32'h0000_0001);
    wr(12'h004, 32'h0003_545A);
    repeat (600) @(posedge clock);
    rd(12'h008);
    chk(rd_data[0], 1'b0);
    wr(12'h000, 32'h0000_0002);
    repeat (80) @(posedge clock);
    chk({serial_clock_line_oe, serial_data_line_oe}, 2'h0);
    chk({serial_clock_line_out, serial_data_line_out}, 2'h0);
    rd(12'h008);
    chk(rd_data, 32'h0000_0001);
    $display("test disable done");
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The link side leaves reset two link edges after release, so a short system
  // reset is enough for both domains.
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_alert();
    t_nak();
    t_dis();
    test_done();
  end
endmodule // two_wire_master_quirks_tb_top
`default_nettype wire
